// >>> src/cdd_regs.vh
// Register offsets, field positions, codes and reset values of the clock divider block.
`ifndef CDD_REGS_VH
`define CDD_REGS_VH

`define CDD_OFS_CH0_CNT     9'h190
`define CDD_OFS_CH0_BYP     9'h191
`define CDD_OFS_CH0_RTE     9'h192
`define CDD_OFS_CH1_CNT     9'h193
`define CDD_OFS_CH1_BYP     9'h194
`define CDD_OFS_CH1_RTE     9'h195
`define CDD_OFS_CH2_CNT     9'h196
`define CDD_OFS_CH2_BYP     9'h197
`define CDD_OFS_CH2_RTE     9'h198
`define CDD_OFS_PREDIV      9'h1e0
`define CDD_OFS_SRCSEL      9'h1e1
`define CDD_OFS_RATIO0      9'h1f0
`define CDD_OFS_RATIO1      9'h1f1
`define CDD_OFS_RATIO2      9'h1f2
`define CDD_OFS_STATUS      9'h1f3

`define CDD_LOW_MSB         7
`define CDD_LOW_LSB         4
`define CDD_HIGH_MSB        3
`define CDD_HIGH_LSB        0
`define CDD_BYP_BIT         7
`define CDD_DIRECT_BIT      1
`define CDD_DUTY_CORRECTION_DISABLE_BIT      0
`define CDD_PREDIV_MSB      2
`define CDD_SRC_MSB         1

`define CDD_SRC_EXT_PRE     2'h0
`define CDD_SRC_EXT_DIR     2'h1
`define CDD_SRC_OSC_PRE     2'h2
`define CDD_SRC_BAD         2'h3

`define CDD_PREDIV_MIN      3'h2
`define CDD_PREDIV_MAX      3'h6
`define CDD_PREDIV_TOPCODE  3'h4

`define CDD_CNT_RST         8'h00
`define CDD_BYP_RST         1'b0
`define CDD_RTE_RST         2'h0
`define CDD_PREDIV_RST      3'h0
`define CDD_SRC_RST         2'h0

`endif

// >>> src/cdd_prediv.v
// Shared pre-divider: divides the selected source by 2 to 6.
`timescale 1ns/1ps
module cdd_prediv (
	input  wire       core_clk_i,
	input  wire       rst_n_i,
	input  wire       in_rise_i,
	input  wire [2:0] ratio_i,
	output wire       div_o,
	output wire       rise_o,
	output wire       fall_o
);
	reg [2:0] cnt_r;
	reg       div_r;
	reg       rise_r;
	reg       fall_r;
	reg [2:0] cnt_nxt;
	reg       div_nxt;

	// High for the first half of the period, rounded down, so odd ratios run short high.
	always @* begin
		cnt_nxt = cnt_r;
		div_nxt = div_r;
		if (in_rise_i) begin
			if (cnt_r >= ratio_i - 3'h1)
				cnt_nxt = 3'h0;
			else
				cnt_nxt = cnt_r + 3'h1;
			div_nxt = (cnt_nxt < {1'b0, ratio_i[2:1]});
		end
	end

	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r  <= 3'h0;
			div_r  <= 1'b0;
			rise_r <= 1'b0;
			fall_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			div_r  <= div_nxt;
			rise_r <= div_nxt & ~div_r;
			fall_r <= ~div_nxt & div_r;
		end
	end

	assign div_o  = div_r;
	assign rise_o = rise_r;
	assign fall_o = fall_r;
endmodule // cdd_prediv

// >>> src/cdd_chdiv.v
// One channel divider with separate high and low counts and duty correction.
`timescale 1ns/1ps
module cdd_chdiv (
	input  wire       core_clk_i,
	input  wire       rst_n_i,
	input  wire       in_rise_i,
	input  wire       in_fall_i,
	input  wire [3:0] high_cnt_i,
	input  wire [3:0] low_cnt_i,
	input  wire       dcc_en_i,
	input  wire       bypass_i,
	output wire       div_o
);
	reg [3:0] cnt_r;
	reg       hi_r;
	reg       pend_r;
	reg       div_r;
	wire      half_w;

	// Odd ratio set as low = high + 1: hold high half an input cycle longer.
	assign half_w = dcc_en_i & (low_cnt_i == high_cnt_i + 4'h1) & (high_cnt_i != 4'hf);

	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r  <= 4'h0;
			hi_r   <= 1'b0;
			pend_r <= 1'b0;
			div_r  <= 1'b0;
		end else if (bypass_i) begin
			cnt_r  <= 4'h0;
			hi_r   <= 1'b0;
			pend_r <= 1'b0;
			div_r  <= 1'b0;
		end else begin
			if (in_rise_i) begin
				if (hi_r && cnt_r == high_cnt_i) begin
					hi_r   <= 1'b0;
					cnt_r  <= 4'h0;
					pend_r <= half_w;
					div_r  <= half_w;
				end else if (!hi_r && cnt_r == low_cnt_i) begin
					hi_r  <= 1'b1;
					cnt_r <= 4'h0;
					div_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 4'h1;
				end
			end else if (in_fall_i && pend_r) begin
				pend_r <= 1'b0;
				div_r  <= 1'b0;
			end
		end
	end

	assign div_o = div_r;
endmodule // cdd_chdiv

// >>> src/cdd_top.v
// Clock distribution divider path: source select, pre-divider and three channels.
//
// Behaviour
// - Source code 00 feeds the external clock and 10 the oscillator through the pre-divider.
// - A channel's direct bit sends the pre-divider input straight to both its pins.
// - With the pre-divider in use the total ratio is pre-divider ratio times channel ratio.
// - The pre-divider divides by 2 to 6 as set by a three-bit field.
// - Each channel byte holds low count in 7:4 and high count in 3:0, each cycles minus one.
// - A divider is high for high+1 and low for low+1 input cycles, ratio 2 to 32.
// - A channel divider counts the clock that currently reaches its input.
// - A channel's bypass bit gives divide by one and idles its divider.
// - Duty correction is on by default and a per-channel bit turns it off.
// - Uncorrected, the duty cycle is the high share of the total ratio.
// - Direct from oscillator gives 50 percent, direct from external keeps its duty.
// - Code 01 feeds the external clock without pre-divider, and code 11 is refused.
`timescale 1ns/1ps
`include "cdd_regs.vh"
module cdd_top (
	input  wire       core_clk_i,
	input  wire       rst_n_i,
	input  wire [8:0] reg_addr_i,
	input  wire [7:0] reg_wdata_i,
	input  wire       reg_wr_i,
	input  wire       reg_rd_i,
	output wire [7:0] reg_rdata_o,
	input  wire       ext_clk_i,
	input  wire       osc_clk_i,
	output wire [5:0] channel_output_pins_o
);
	localparam NCH = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	function [8:0] ch_ofs;
		input [1:0] ch;
		input [1:0] kind;
		begin
			ch_ofs = `CDD_OFS_CH0_CNT + ({7'h00, ch} << 1) + {7'h00, ch} + {7'h00, kind};
		end
	endfunction

	// Codes above the top one clamp to the largest ratio.
	function [2:0] pre_ratio;
		input [2:0] code;
		begin
			if (code > `CDD_PREDIV_TOPCODE)
				pre_ratio = `CDD_PREDIV_MAX;
			else
				pre_ratio = code + `CDD_PREDIV_MIN;
		end
	endfunction

	function [7:0] total_ratio;
		input [2:0] pr;
		input       use_pre;
		input       byp;
		input       direct;
		input [7:0] cnt;
		reg   [5:0] chd;
		reg   [8:0] prod;
		begin
			chd  = 6'h00;
			prod = 9'h000;
			if (byp)
				chd = 6'h01;
			else
				chd = {2'h0, cnt[`CDD_LOW_MSB:`CDD_LOW_LSB]}
				    + {2'h0, cnt[`CDD_HIGH_MSB:`CDD_HIGH_LSB]} + 6'h02;
			if (use_pre)
				prod = {6'h00, pr} * {3'h0, chd};
			else
				prod = {3'h0, chd};
			if (direct)
				total_ratio = 8'h01;
			else
				total_ratio = prod[7:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	reg [7:0] cnt_r [0:NCH-1];
	reg [2:0] byp_r;
	reg [2:0] direct_r;
	reg [2:0] duty_correction_disable_r;
	reg [2:0] prediv_r;
	reg [1:0] src_r;
	reg [7:0] rdata_r;
	reg [7:0] rd_nxt;
	integer   c_wr;
	integer   c_lvl;
	integer   c_pin;

	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (c_wr = 0; c_wr < NCH; c_wr = c_wr + 1) begin
				cnt_r[c_wr] <= `CDD_CNT_RST;
			end
			byp_r    <= {NCH{`CDD_BYP_RST}};
			direct_r <= {NCH{1'b0}};
			duty_correction_disable_r <= {NCH{1'b0}};
			prediv_r <= `CDD_PREDIV_RST;
			src_r    <= `CDD_SRC_RST;
		end else if (reg_wr_i) begin
			for (c_wr = 0; c_wr < NCH; c_wr = c_wr + 1) begin
				if (reg_addr_i == ch_ofs(c_wr[1:0], 2'h0))
					cnt_r[c_wr] <= reg_wdata_i;
				if (reg_addr_i == ch_ofs(c_wr[1:0], 2'h1))
					byp_r[c_wr] <= reg_wdata_i[`CDD_BYP_BIT];
				if (reg_addr_i == ch_ofs(c_wr[1:0], 2'h2)) begin
					direct_r[c_wr] <= reg_wdata_i[`CDD_DIRECT_BIT];
					duty_correction_disable_r[c_wr] <= reg_wdata_i[`CDD_DUTY_CORRECTION_DISABLE_BIT];
				end
			end
			if (reg_addr_i == `CDD_OFS_PREDIV)
				prediv_r <= reg_wdata_i[`CDD_PREDIV_MSB:0];
			// The forbidden code is dropped so the oscillator bypasses the pre-divider only on a channel's direct route.
			if (reg_addr_i == `CDD_OFS_SRCSEL &&
			    reg_wdata_i[`CDD_SRC_MSB:0] != `CDD_SRC_BAD)
				src_r <= reg_wdata_i[`CDD_SRC_MSB:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Source synchronisers and edge detection

	reg  ext_s1_r;
	reg  ext_s2_r;
	reg  ext_s3_r;
	reg  osc_s1_r;
	reg  osc_s2_r;
	reg  osc_s3_r;
	wire src_lvl_w;
	wire src_prv_w;
	wire src_rise_w;
	wire ext_rise_w;
	wire ext_fall_w;
	wire use_pre_w;

	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
		end else begin
			ext_s1_r <= ext_clk_i;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
			osc_s1_r <= osc_clk_i;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end

	// The sources run far below this clock; edges are only sampled.
	assign src_lvl_w  = (src_r == `CDD_SRC_OSC_PRE) ? osc_s2_r : ext_s2_r;
	assign src_prv_w  = (src_r == `CDD_SRC_OSC_PRE) ? osc_s3_r : ext_s3_r;
	assign src_rise_w = src_lvl_w & ~src_prv_w;
	assign ext_rise_w = ext_s2_r & ~ext_s3_r;
	assign ext_fall_w = ~ext_s2_r & ext_s3_r;
	assign use_pre_w  = (src_r != `CDD_SRC_EXT_DIR);

	////////////////////////////////////////////////////////////////////////////////
	// Pre-divider and channel input selection

	wire pre_lvl_w;
	wire pre_rise_w;
	wire pre_fall_w;
	wire in_lvl_w;
	wire in_rise_w;
	wire in_fall_w;

	wire [2:0] pre_ratio_w;
	wire       src_fall_w;
	wire       pre_corr_w;
	wire       in_corr_w;
	reg        stretch_r;

	assign pre_ratio_w = pre_ratio(prediv_r);

	cdd_prediv u_prediv (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.in_rise_i  (src_rise_w),
		.ratio_i    (pre_ratio_w),
		.div_o      (pre_lvl_w),
		.rise_o     (pre_rise_w),
		.fall_o     (pre_fall_w)
	);

	// Channels see the pre-divider output or, for code 01, the external clock itself.
	assign in_lvl_w  = use_pre_w ? pre_lvl_w : ext_s2_r;
	assign in_rise_w = use_pre_w ? pre_rise_w : ext_rise_w;
	assign in_fall_w = use_pre_w ? pre_fall_w : ext_fall_w;

	// An odd pre-divider runs short high; with correction on, a bypassed channel holds it
	// high to the next source fall. This needs a source half period of two core cycles.
	assign src_fall_w = ~src_lvl_w & src_prv_w;

	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			stretch_r <= 1'b0;
		else if (pre_fall_w && pre_ratio_w[0])
			stretch_r <= 1'b1;
		else if (src_fall_w)
			stretch_r <= 1'b0;
	end

	assign pre_corr_w = pre_lvl_w | stretch_r | (pre_fall_w & pre_ratio_w[0]);
	assign in_corr_w  = use_pre_w ? pre_corr_w : ext_s2_r;

	////////////////////////////////////////////////////////////////////////////////
	// Channel dividers and output pins

	wire [NCH-1:0] div_w;
	reg  [NCH-1:0] lvl_nxt;
	reg  [5:0]     pins_r;

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_ch
			cdd_chdiv u_chdiv (
				.core_clk_i (core_clk_i),
				.rst_n_i    (rst_n_i),
				.in_rise_i  (in_rise_w),
				.in_fall_i  (in_fall_w),
				.high_cnt_i (cnt_r[g][`CDD_HIGH_MSB:`CDD_HIGH_LSB]),
				.low_cnt_i  (cnt_r[g][`CDD_LOW_MSB:`CDD_LOW_LSB]),
				.dcc_en_i   (~duty_correction_disable_r[g]),
				.bypass_i   (byp_r[g] | direct_r[g]),
				.div_o      (div_w[g])
			);
		end
	endgenerate

	// Direct route wins over bypass, which wins over the divided clock.
	always @* begin
		for (c_lvl = 0; c_lvl < NCH; c_lvl = c_lvl + 1) begin
			if (direct_r[c_lvl])
				lvl_nxt[c_lvl] = src_lvl_w;
			else if (byp_r[c_lvl] && duty_correction_disable_r[c_lvl])
				lvl_nxt[c_lvl] = in_lvl_w;
			else if (byp_r[c_lvl])
				lvl_nxt[c_lvl] = in_corr_w;
			else
				lvl_nxt[c_lvl] = div_w[c_lvl];
		end
	end

	// Both pins of a pair carry the same clock.
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pins_r <= 6'h00;
		end else begin
			for (c_pin = 0; c_pin < NCH; c_pin = c_pin + 1) begin
				pins_r[2*c_pin]   <= lvl_nxt[c_pin];
				pins_r[2*c_pin+1] <= lvl_nxt[c_pin];
			end
		end
	end

	assign channel_output_pins_o = pins_r;

	////////////////////////////////////////////////////////////////////////////////
	// Register read-back

	always @* begin
		rd_nxt = 8'h00;
		case (reg_addr_i)
			`CDD_OFS_CH0_CNT: begin
				rd_nxt = cnt_r[0];
			end
			`CDD_OFS_CH0_BYP: begin
				rd_nxt = {byp_r[0], 7'h00};
			end
			`CDD_OFS_CH0_RTE: begin
				rd_nxt = {6'h00, direct_r[0], duty_correction_disable_r[0]};
			end
			`CDD_OFS_CH1_CNT: begin
				rd_nxt = cnt_r[1];
			end
			`CDD_OFS_CH1_BYP: begin
				rd_nxt = {byp_r[1], 7'h00};
			end
			`CDD_OFS_CH1_RTE: begin
				rd_nxt = {6'h00, direct_r[1], duty_correction_disable_r[1]};
			end
			`CDD_OFS_CH2_CNT: begin
				rd_nxt = cnt_r[2];
			end
			`CDD_OFS_CH2_BYP: begin
				rd_nxt = {byp_r[2], 7'h00};
			end
			`CDD_OFS_CH2_RTE: begin
				rd_nxt = {6'h00, direct_r[2], duty_correction_disable_r[2]};
			end
			`CDD_OFS_PREDIV: begin
				rd_nxt = {5'h00, prediv_r};
			end
			`CDD_OFS_SRCSEL: begin
				rd_nxt = {6'h00, src_r};
			end
			`CDD_OFS_RATIO0: begin
				rd_nxt = total_ratio(pre_ratio_w, use_pre_w, byp_r[0],
				                     direct_r[0], cnt_r[0]);
			end
			`CDD_OFS_RATIO1: begin
				rd_nxt = total_ratio(pre_ratio_w, use_pre_w, byp_r[1],
				                     direct_r[1], cnt_r[1]);
			end
			`CDD_OFS_RATIO2: begin
				rd_nxt = total_ratio(pre_ratio_w, use_pre_w, byp_r[2],
				                     direct_r[2], cnt_r[2]);
			end
			`CDD_OFS_STATUS: begin
				rd_nxt = {3'h0, src_lvl_w, pre_lvl_w, pins_r[4], pins_r[2], pins_r[0]};
			end
			default: begin
				rd_nxt = 8'h00;
			end
		endcase
	end

	// Read data stand for one cycle per cycle of read strobe and are zero otherwise.
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rdata_r <= 8'h00;
		else if (reg_rd_i)
			rdata_r <= rd_nxt;
		else
			rdata_r <= 8'h00;
	end

	assign reg_rdata_o = rdata_r;
endmodule // cdd_top

// >>> verification/cdd_top_properties.sv
// Checker of the register port and the output pairs of the clock divider block.
`timescale 1ns/1ps
module cdd_top_checker (
	input wire logic       core_clk_i,
	input wire logic       rst_n_i,
	input wire logic [8:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       ext_clk_i,
	input wire logic       osc_clk_i,
	input wire logic [5:0] channel_output_pins_o
);
	logic [7:0] cnt0_r;
	logic [1:0] src_r;
	logic [3:0] quiet_r;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////////////////
	// Shadows of two registers; a source code of 11 must never land.
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt0_r <= 8'h00;
			src_r <= 2'h0;
			quiet_r <= 4'h0;
		end else begin
			if (reg_wr_i && reg_addr_i == 9'h190)
				cnt0_r <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == 9'h1e1 && reg_wdata_i[1:0] != 2'h3)
				src_r <= reg_wdata_i[1:0];
			// The pipeline from pin to output is shorter than twelve cycles.
			if (reg_wr_i || !$stable(ext_clk_i) || !$stable(osc_clk_i))
				quiet_r <= 4'h0;
			else if (quiet_r != 4'hf)
				quiet_r <= quiet_r + 4'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	sequence s_rd(logic [8:0] a);
		reg_rd_i && reg_addr_i == a;
	endsequence
	property p_pair_equal;
		channel_output_pins_o[0] == channel_output_pins_o[1] &&
			channel_output_pins_o[2] == channel_output_pins_o[3] &&
			channel_output_pins_o[4] == channel_output_pins_o[5];
	endproperty
	property p_idle_zero;
		!reg_rd_i |=> reg_rdata_o == 8'h00;
	endproperty
	property p_cnt_back;
		s_rd(9'h190) |=> reg_rdata_o == cnt0_r;
	endproperty
	property p_src_back;
		s_rd(9'h1e1) |=> reg_rdata_o == {6'h00, src_r};
	endproperty
	property p_unmapped;
		s_rd(9'h100) |=> reg_rdata_o == 8'h00;
	endproperty
	property p_byp_bits;
		s_rd(9'h191) |=> reg_rdata_o[6:0] == 7'h00;
	endproperty
	property p_rte_bits;
		s_rd(9'h192) |=> reg_rdata_o[7:2] == 6'h00;
	endproperty
	property p_pre_bits;
		s_rd(9'h1e0) |=> reg_rdata_o[7:3] == 5'h00;
	endproperty
	property p_still;
		quiet_r >= 4'hc |-> $stable(channel_output_pins_o);
	endproperty
	a_pair_equal: assert property (p_pair_equal) else $error("pair pins differ");
	a_idle_zero: assert property (p_idle_zero) else $error("read data without read");
	a_cnt_back: assert property (p_cnt_back) else $error("count readback wrong");
	a_src_back: assert property (p_src_back) else $error("source readback wrong");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_byp_bits: assert property (p_byp_bits) else $error("bypass spare bits set");
	a_rte_bits: assert property (p_rte_bits) else $error("route spare bits set");
	a_pre_bits: assert property (p_pre_bits) else $error("ratio spare bits set");
	a_still: assert property (p_still) else $error("pins moved without source");
endmodule // cdd_top_checker

bind cdd_top cdd_top_checker i_chk (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .ext_clk_i(ext_clk_i), .osc_clk_i(osc_clk_i),
	.channel_output_pins_o(channel_output_pins_o));

// >>> verification/cdd_sink.sv
// Receiver model of one output pair: times its edges in core clock cycles.
`timescale 1ns/1ps
module cdd_sink (
	input  wire logic        core_clk_i,
	input  wire logic        pin_i,
	output logic      [15:0] period_o,
	output logic      [15:0] high_o,
	output logic      [15:0] rises_o
);
	logic [15:0] cnt_r = 16'h0000;
	logic        last_r = 1'b0;
	initial rises_o = 16'h0000;
	always @(posedge core_clk_i) begin
		last_r <= pin_i;
		cnt_r <= cnt_r + 16'h1;
		if (pin_i && !last_r) begin
			period_o <= cnt_r + 16'h1;
			rises_o <= rises_o + 16'h1;
			cnt_r <= 16'h0000;
		end
		if (!pin_i && last_r)
			high_o <= cnt_r + 16'h1;
	end
endmodule // cdd_sink

// >>> verification/cdd_top_bench.sv
// Self-checking bench of the clock divider block.
`timescale 1ns/1ps
module cdd_top_bench;
	logic        core_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [8:0]  addr = 9'h000;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        ext = 1'b0;
	logic        osc = 1'b0;
	logic        run = 1'b1;
	logic [1:0]  ecnt = 2'h0;
	logic [1:0]  ocnt = 2'h0;
	logic [7:0]  rdata;
	logic [5:0]  pins;
	logic [15:0] per [3];
	logic [15:0] hi [3];
	logic [15:0] rises [3];
	int          err_count = 0;
	int          total_checks = 0;
	always #12.5 core_clk_i = ~core_clk_i;
	// Sources come from core counters so periods are whole: ext 8, osc 6 cycles.
	always @(posedge core_clk_i) begin
		if (run) begin
			ecnt <= ecnt + 2'h1;
			if (ecnt == 2'h3)
				ext <= ~ext;
			ocnt <= (ocnt == 2'h2) ? 2'h0 : ocnt + 2'h1;
			if (ocnt == 2'h2)
				osc <= ~osc;
		end
	end
	cdd_top i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.ext_clk_i(ext), .osc_clk_i(osc), .channel_output_pins_o(pins));
	for (genvar g = 0; g < 3; g++) begin : g_sink
		cdd_sink i_sink (.core_clk_i(core_clk_i), .pin_i(pins[2*g]), .period_o(per[g]),
			.high_o(hi[g]), .rises_o(rises[g]));
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: register got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_time(input logic [15:0] got, input logic [15:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s got %0d exp %0d", $time, msg, got, exp);
		end
	endtask
	task automatic chk_pins(input logic [5:0] got, input logic [5:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: pins moved, got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk_i);
		wr <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic rd_reg(input logic [8:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk_i);
		rd <= 1'b0;
		#1;
		chk_reg(rdata, e);
		@(posedge core_clk_i);
	endtask
	task automatic wr_rd(input logic [8:0] a, input logic [7:0] d, input logic [7:0] e);
		wr_reg(a, d);
		rd_reg(a, e);
	endtask
	// Waits four rises of one pair so the last period is clear of config changes.
	task automatic meas(input int c, input logic [15:0] p, input logic [15:0] h);
		logic [15:0] r0;
		int          n;
		r0 = rises[c];
		n = 0;
		while (rises[c] - r0 < 16'h4 && n < 3000) begin
			@(posedge core_clk_i);
			n++;
		end
		if (n >= 3000) begin
			err_count++;
			$display("mismatch at %0t: pair %0d not clocking", $time, c);
			stop_test();
		end else begin
			#1;
			chk_time(per[c], p, "period");
			chk_time(hi[c], h, "high time");
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic regs_test();
		for (int i = 0; i < 9; i++)
			rd_reg(9'(9'h190 + i), 8'h00);
		rd_reg(9'h1e0, 8'h00);
		rd_reg(9'h1e1, 8'h00);
		wr_rd(9'h190, 8'ha5, 8'ha5);
		wr_rd(9'h191, 8'hff, 8'h80);
		wr_rd(9'h192, 8'hff, 8'h03);
		wr_rd(9'h1e0, 8'hff, 8'h07);
		wr_rd(9'h1e1, 8'h02, 8'h02);
		wr_rd(9'h1e1, 8'h03, 8'h02);
		wr_rd(9'h100, 8'hff, 8'h00);
		wr_reg(9'h191, 8'h00);
		wr_reg(9'h192, 8'h00);
		wr_reg(9'h1e0, 8'h00);
		wr_reg(9'h1e1, 8'h00);
	endtask
	task automatic prediv_test();
		wr_reg(9'h190, 8'h21);
		wr_reg(9'h192, 8'h01);
		for (int k = 0; k < 5; k++) begin
			wr_reg(9'h1e0, 8'(k));
			meas(0, 16'(40 * (k + 2)), 16'(16 * (k + 2)));
			rd_reg(9'h1f0, 8'(5 * (k + 2)));
		end
		// Odd pre-divider of 3 into a bypassed channel: corrected, then uncorrected.
		wr_reg(9'h1e0, 8'h01);
		wr_reg(9'h194, 8'h80);
		rd_reg(9'h1f1, 8'h03);
		meas(1, 16'd24, 16'd12);
		wr_reg(9'h195, 8'h01);
		meas(1, 16'd24, 16'd8);
		wr_reg(9'h194, 8'h00);
	endtask
	task automatic direct_test();
		wr_reg(9'h1e1, 8'h02);
		wr_reg(9'h192, 8'h02);
		rd_reg(9'h1f0, 8'h01);
		meas(0, 16'd6, 16'd3);
		wr_reg(9'h1e1, 8'h00);
		meas(0, 16'd8, 16'd4);
		wr_reg(9'h192, 8'h00);
	endtask
	task automatic ext_test();
		wr_reg(9'h1e1, 8'h01);
		wr_reg(9'h193, 8'h00);
		meas(1, 16'd16, 16'd8);
		rd_reg(9'h1f1, 8'h02);
		wr_reg(9'h197, 8'h80);
		rd_reg(9'h1f2, 8'h01);
		meas(2, 16'd8, 16'd4);
		wr_reg(9'h190, 8'h21);
		meas(0, 16'd40, 16'd20);
		wr_reg(9'h190, 8'hff);
		meas(0, 16'd256, 16'd128);
	endtask
	task automatic still_test();
		logic [5:0] snap;
		run <= 1'b0;
		repeat (16) @(posedge core_clk_i);
		snap = pins;
		repeat (40) @(posedge core_clk_i);
		chk_pins(pins, snap);
		run <= 1'b1;
	endtask
	initial begin
		repeat (12) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(posedge core_clk_i);
		regs_test();
		prediv_test();
		direct_test();
		ext_test();
		still_test();
		stop_test();
	end
endmodule // cdd_top_bench
